// ### core/dsi_params.svh
// Constants for the DDR SDRAM init, mode and power-down ends
`ifndef DSI_PARAMS_SVH
`define DSI_PARAMS_SVH

`define DSI_CLK_PERIOD_NS 40
`define DSI_T_PWRUP_US 200
`define DSI_PWRUP_CYC (((`DSI_T_PWRUP_US * 1000) + `DSI_CLK_PERIOD_NS - 1) / `DSI_CLK_PERIOD_NS)
`define DSI_T_RC_NS 55
`define DSI_RC_CYC ((`DSI_T_RC_NS + `DSI_CLK_PERIOD_NS - 1) / `DSI_CLK_PERIOD_NS)
`define DSI_T_RP_NS 15
`define DSI_RP_CYC ((`DSI_T_RP_NS + `DSI_CLK_PERIOD_NS - 1) / `DSI_CLK_PERIOD_NS)
`define DSI_T_RFC_NS 70
`define DSI_RFC_CYC ((`DSI_T_RFC_NS + `DSI_CLK_PERIOD_NS - 1) / `DSI_CLK_PERIOD_NS)
`define DSI_MRD_CYC 2
`define DSI_DLL_LOCK_CYC 200
`define DSI_REF_COUNT 2

`define DSI_OFS_CTRL 8'h00
`define DSI_OFS_MODE 8'h04
`define DSI_OFS_EMODE 8'h08
`define DSI_OFS_STATUS 8'h0C

`define DSI_MODE_RST 13'h0032
`define DSI_EMODE_RST 1'h0

`define DSI_CTRL_PD_BIT 0
`define DSI_CTRL_SR_BIT 1
`define DSI_CTRL_MRS_BIT 2
`define DSI_CTRL_EMRS_BIT 3

`define DSI_BL_LSB 0
`define DSI_BT_BIT 3
`define DSI_CL_LSB 4
`define DSI_TM_BIT 7
`define DSI_DLLRST_BIT 8
`define DSI_AP_BIT 10
`define DSI_EDLL_BIT 0

`define DSI_BL2 3'h1
`define DSI_BL4 3'h2
`define DSI_BL8 3'h3
`define DSI_CL3 3'h3
`define DSI_CL25 3'h6

`endif

// ### core/dsi_pkg.sv
// Types and command coding shared by both ends
package dsi_pkg;

  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_BST, CMD_READ, CMD_WRITE, CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS
  } dsi_cmd_type;

  // Decode of cs_n, ras_n, cas_n, we_n
  function automatic dsi_cmd_type dsi_decode(input logic [3:0] pins);
    unique case (pins)
      4'h7: return CMD_NOP;
      4'h6: return CMD_BST;
      4'h5: return CMD_READ;
      4'h4: return CMD_WRITE;
      4'h3: return CMD_ACT;
      4'h2: return CMD_PRE;
      4'h1: return CMD_REF;
      4'h0: return CMD_MRS;
      default: return CMD_DESEL;
    endcase
  endfunction

  function automatic logic [3:0] dsi_pins(input dsi_cmd_type cmd);
    unique case (cmd)
      CMD_NOP: return 4'h7;
      CMD_BST: return 4'h6;
      CMD_READ: return 4'h5;
      CMD_WRITE: return 4'h4;
      CMD_ACT: return 4'h3;
      CMD_PRE: return 4'h2;
      CMD_REF: return 4'h1;
      CMD_MRS: return 4'h0;
      default: return 4'hF;
    endcase
  endfunction

endpackage

// ### core/dsi_if.sv
// Command pins between controller and SDRAM
interface dsi_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  modport ctrl_mp (output cke, output cs_n, output ras_n, output cas_n, output we_n, output ba, output addr);
  modport dev_mp (input cke, input cs_n, input ras_n, input cas_n, input we_n, input ba, input addr);
endinterface

// ### core/dsi_burst_order.sv
// Column order inside a burst
`include "dsi_params.svh"
module dsi_burst_order (
  // Mode
  input wire logic [2:0] bl_code,
  input wire logic interleave,
  // Position
  input wire logic [2:0] start_col,
  input wire logic [2:0] beat,
  output logic [2:0] col
);
  logic [2:0] mask;
  logic [2:0] low;

  always_comb begin
    unique case (bl_code)
      `DSI_BL2: mask = 3'h1;
      `DSI_BL4: mask = 3'h3;
      default: mask = 3'h7;
    endcase
    // Sequential wraps inside the block, interleave xors the beat
    low = interleave ? (start_col ^ beat) : 3'(start_col + beat);
    col = (low & mask) | (start_col & ~mask);
  end
endmodule

// ### core/dsi_dev.sv
// SDRAM end: power-down, self-refresh, mode and extended mode registers
`include "dsi_params.svh"
module dsi_dev (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command pins
  dsi_if.dev_mp ddr,
  // Burst position
  input wire logic [2:0] start_col,
  input wire logic [2:0] beat,
  output logic [2:0] burst_col,
  // Mode state
  output logic [2:0] bl_code,
  output logic interleave,
  output logic [2:0] cl_code,
  output logic test_mode,
  output logic mode_legal,
  output logic dll_on,
  output logic dll_locked,
  output logic power_down,
  output logic self_refresh
);
  typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_PD = 2'b01, DS_SR = 2'b10} dsi_dev_st_type;

  dsi_dev_st_type st_r, st_nxt;
  logic cke_prev_r;
  logic [12:0] mode_r, mode_nxt;
  logic [11:0] emode_r, emode_nxt;
  logic dll_on_r, dll_on_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic [2:0] col_r;
  logic [2:0] col_w;
  dsi_pkg::dsi_cmd_type cmd;

  assign cmd = dsi_pkg::dsi_decode({ddr.cs_n, ddr.ras_n, ddr.cas_n, ddr.we_n});

  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    emode_nxt = emode_r;
    dll_on_nxt = dll_on_r;
    lock_nxt = (lock_r != 8'h00) ? 8'(lock_r - 8'h01) : lock_r;
    if (!cke_prev_r) begin
      // Pins ignored; a rising enable restarts the clock at once
      if (ddr.cke) begin
        st_nxt = DS_IDLE;
        if (st_r == DS_SR) begin
          dll_on_nxt = 1'b1;
          lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
        end
      end
    end else if (st_r == DS_IDLE) begin
      if (!ddr.cke && (cmd == dsi_pkg::CMD_DESEL || cmd == dsi_pkg::CMD_NOP)) begin
        st_nxt = DS_PD;
      end else if (!ddr.cke && cmd == dsi_pkg::CMD_REF) begin
        st_nxt = DS_SR;
      end else if (cmd == dsi_pkg::CMD_MRS && !ddr.ba[0]) begin
        mode_nxt = ddr.addr;
        if (ddr.addr[`DSI_DLLRST_BIT]) begin
          lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
        end
      end else if (cmd == dsi_pkg::CMD_MRS) begin
        emode_nxt = {ddr.ba[1], ddr.addr[10:0]};
        dll_on_nxt = !ddr.addr[`DSI_EDLL_BIT];
        if (!ddr.addr[`DSI_EDLL_BIT]) begin
          lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= DS_IDLE;
      cke_prev_r <= 1'b0;
      mode_r <= 13'h0000;
      emode_r <= 12'h000;
      dll_on_r <= 1'b0;
      lock_r <= 8'h00;
      col_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cke_prev_r <= ddr.cke;
      mode_r <= mode_nxt;
      emode_r <= emode_nxt;
      dll_on_r <= dll_on_nxt;
      lock_r <= lock_nxt;
      col_r <= col_w;
    end
  end

  dsi_burst_order u_order (
    .bl_code(mode_r[`DSI_BL_LSB +: 3]),
    .interleave(mode_r[`DSI_BT_BIT]),
    .start_col(start_col),
    .beat(beat),
    .col(col_w)
  );

  // Field decode straight from the stored register
  assign burst_col = col_r;
  assign bl_code = mode_r[`DSI_BL_LSB +: 3];
  assign interleave = mode_r[`DSI_BT_BIT];
  assign cl_code = mode_r[`DSI_CL_LSB +: 3];
  assign test_mode = mode_r[`DSI_TM_BIT];
  assign mode_legal = (mode_r[`DSI_BL_LSB +: 3] == `DSI_BL2 || mode_r[`DSI_BL_LSB +: 3] == `DSI_BL4 ||
                       mode_r[`DSI_BL_LSB +: 3] == `DSI_BL8) &&
                      (mode_r[`DSI_CL_LSB +: 3] == `DSI_CL3 || mode_r[`DSI_CL_LSB +: 3] == `DSI_CL25);
  assign dll_on = dll_on_r;
  assign dll_locked = dll_on_r && (lock_r == 8'h00);
  assign power_down = (st_r == DS_PD);
  assign self_refresh = (st_r == DS_SR);
endmodule

// ### core/dsi_ctrl.sv
// Controller end: AHB-Lite registers, power-up sequence, mode writes, power saving
`include "dsi_params.svh"
// Notes on behaviour
// - CKE fall with NOP/REF enters PD/SR
// - Enter PD/SR only with all banks idle
// - CKE low last cycle: pins ignored
// - Wait tRC after self-refresh exit
// - CKE rise restarts internal clock immediately
// - Hold CKE low 200us with clock
// - Precharge all, then EMRS enabling DLL
// - MRS with DLL reset, wait 200
// - Precharge, two refreshes, final MRS
// - DLL reset step skippable; still wait 200
// - MRS captures A0-A12 when BA0 low
// - Write mode register after extended mode
// - Mode write takes two clock cycles
// - Rewrite mode only with banks idle
// - Fields: BL, type, latency, DLL reset
// - Test mode bit always written low
// - Burst column order sequential or interleaved
// - 200 cycles after DLL enable before read
// - Self-refresh exit re-enables DLL
// - EMRS captures A0-A10, BA1; A0 DLL
// - EMRS: all pins low but A0, BA0
module dsi_ctrl #(
  parameter int PWRUP_CYC = `DSI_PWRUP_CYC,
  parameter int REF_COUNT = `DSI_REF_COUNT,
  parameter bit SKIP_DLL_RESET = 1'b0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Command pins
  dsi_if.ctrl_mp ddr
);
  typedef enum logic [3:0] {
    CS_RESET = 4'b0000, CS_PWRUP = 4'b0001, CS_CKE = 4'b1111, CS_PALL1 = 4'b0011,
    CS_EMRS = 4'b0010, CS_MRSDLL = 4'b0110, CS_PALL2 = 4'b0111, CS_REF = 4'b0101,
    CS_MRSOP = 4'b0100, CS_IDLE = 4'b1100, CS_PD = 4'b1101, CS_SR = 4'b1000
  } dsi_ctrl_st_type;

  // Counter widths are 16 and 4 bits
  if (PWRUP_CYC < 1 || PWRUP_CYC > 65535) begin : g_pwrup_chk
    $error("PWRUP_CYC out of range");
  end
  if (REF_COUNT < 2 || REF_COUNT > 15) begin : g_ref_chk
    $error("REF_COUNT must be 2 to 15");
  end

  // Bus and software-visible state
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [12:0] mode_r, mode_nxt;
  logic emode_r, emode_nxt;
  logic pd_req_r, pd_req_nxt;
  logic sr_req_r, sr_req_nxt;
  logic mrs_pend_r, mrs_pend_nxt;
  logic emrs_pend_r, emrs_pend_nxt;
  // Sequencer state
  dsi_ctrl_st_type st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic [3:0] refs_r, refs_nxt;
  logic done_r, done_nxt;
  logic mrs_take, emrs_take;
  dsi_pkg::dsi_cmd_type cmd_nxt;
  logic [3:0] pins_r;
  logic cke_r, cke_nxt;
  logic [1:0] ba_r, ba_nxt;
  logic [12:0] addr_r, addr_nxt;
  logic addr_ok;
  logic [31:0] status_w;

  assign addr_ok = hsel && htrans[1] && hready;
  assign status_w = {26'h0, lock_r == 8'h00 && !emode_r && done_r, st_r == CS_SR, st_r == CS_PD,
                     cnt_r != 16'h0000, !done_r, done_r};

  always_comb begin
    wr_pend_nxt = addr_ok && hwrite;
    wr_addr_nxt = addr_ok ? haddr : wr_addr_r;
    hrdata_nxt = 32'h0000_0000;
    mode_nxt = mode_r;
    emode_nxt = emode_r;
    pd_req_nxt = pd_req_r;
    sr_req_nxt = sr_req_r;
    // A hardware take and a new software request in one cycle leave the request standing
    mrs_pend_nxt = mrs_pend_r && !mrs_take;
    emrs_pend_nxt = emrs_pend_r && !emrs_take;
    if (addr_ok && !hwrite) begin
      unique case (haddr)
        `DSI_OFS_CTRL: hrdata_nxt = {28'h0, emrs_pend_r, mrs_pend_r, sr_req_r, pd_req_r};
        `DSI_OFS_MODE: hrdata_nxt = {19'h0, mode_r};
        `DSI_OFS_EMODE: hrdata_nxt = {31'h0, emode_r};
        `DSI_OFS_STATUS: hrdata_nxt = status_w;
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        `DSI_OFS_CTRL: begin
          pd_req_nxt = hwdata[`DSI_CTRL_PD_BIT];
          sr_req_nxt = hwdata[`DSI_CTRL_SR_BIT];
          mrs_pend_nxt = mrs_pend_nxt || hwdata[`DSI_CTRL_MRS_BIT];
          emrs_pend_nxt = emrs_pend_nxt || hwdata[`DSI_CTRL_EMRS_BIT];
        end
        `DSI_OFS_MODE: mode_nxt = hwdata[12:0];
        `DSI_OFS_EMODE: emode_nxt = hwdata[`DSI_EDLL_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      mode_r <= `DSI_MODE_RST;
      emode_r <= `DSI_EMODE_RST;
      pd_req_r <= 1'b0;
      sr_req_r <= 1'b0;
      mrs_pend_r <= 1'b0;
      emrs_pend_r <= 1'b0;
      hreadyout <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      mode_r <= mode_nxt;
      emode_r <= emode_nxt;
      pd_req_r <= pd_req_nxt;
      sr_req_r <= sr_req_nxt;
      mrs_pend_r <= mrs_pend_nxt;
      emrs_pend_r <= emrs_pend_nxt;
      hreadyout <= 1'b1;
    end
  end

  assign hrdata = hrdata_r;
  assign hresp = 1'b0;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != 16'h0000) ? 16'(cnt_r - 16'h0001) : cnt_r;
    lock_nxt = (lock_r != 8'h00) ? 8'(lock_r - 8'h01) : lock_r;
    refs_nxt = refs_r;
    done_nxt = done_r;
    cke_nxt = cke_r;
    cmd_nxt = dsi_pkg::CMD_NOP;
    ba_nxt = 2'b00;
    addr_nxt = 13'h0000;
    mrs_take = 1'b0;
    emrs_take = 1'b0;
    if (cnt_r == 16'h0000) begin
      unique case (st_r)
        CS_RESET: begin
          cke_nxt = 1'b0;
          cnt_nxt = 16'(PWRUP_CYC - 1);
          st_nxt = CS_PWRUP;
        end
        CS_PWRUP: begin
          cke_nxt = 1'b1;
          st_nxt = CS_PALL1;
        end
        CS_PALL1, CS_CKE: begin
          cmd_nxt = dsi_pkg::CMD_PRE;
          addr_nxt[`DSI_AP_BIT] = 1'b1;
          cnt_nxt = 16'(`DSI_RP_CYC - 1);
          st_nxt = CS_EMRS;
        end
        CS_EMRS: begin
          cmd_nxt = dsi_pkg::CMD_MRS;
          ba_nxt = 2'b01;
          lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
          if (SKIP_DLL_RESET) begin
            cnt_nxt = 16'(`DSI_DLL_LOCK_CYC - 1);
            st_nxt = CS_PALL2;
          end else begin
            cnt_nxt = 16'(`DSI_MRD_CYC - 1);
            st_nxt = CS_MRSDLL;
          end
        end
        CS_MRSDLL: begin
          cmd_nxt = dsi_pkg::CMD_MRS;
          addr_nxt = mode_r;
          addr_nxt[`DSI_TM_BIT] = 1'b0;
          addr_nxt[`DSI_DLLRST_BIT] = 1'b1;
          lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
          cnt_nxt = 16'(`DSI_DLL_LOCK_CYC - 1);
          st_nxt = CS_PALL2;
        end
        CS_PALL2: begin
          cmd_nxt = dsi_pkg::CMD_PRE;
          addr_nxt[`DSI_AP_BIT] = 1'b1;
          cnt_nxt = 16'(`DSI_RP_CYC - 1);
          refs_nxt = 4'h0;
          st_nxt = CS_REF;
        end
        CS_REF: begin
          cmd_nxt = dsi_pkg::CMD_REF;
          cnt_nxt = 16'(`DSI_RFC_CYC - 1);
          refs_nxt = 4'(refs_r + 4'h1);
          if (refs_r == 4'(REF_COUNT - 1)) begin
            st_nxt = CS_MRSOP;
          end
        end
        CS_MRSOP: begin
          cmd_nxt = dsi_pkg::CMD_MRS;
          addr_nxt = mode_r;
          addr_nxt[`DSI_TM_BIT] = 1'b0;
          addr_nxt[`DSI_DLLRST_BIT] = 1'b0;
          cnt_nxt = 16'(`DSI_MRD_CYC - 1);
          done_nxt = 1'b1;
          st_nxt = CS_IDLE;
        end
        CS_IDLE: begin
          // This controller never opens a row, so every bank is idle here
          if (emrs_pend_r) begin
            cmd_nxt = dsi_pkg::CMD_MRS;
            ba_nxt = 2'b01;
            addr_nxt[`DSI_EDLL_BIT] = emode_r;
            if (!emode_r) begin
              lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
            end
            emrs_take = 1'b1;
            cnt_nxt = 16'(`DSI_MRD_CYC - 1);
          end else if (mrs_pend_r) begin
            cmd_nxt = dsi_pkg::CMD_MRS;
            addr_nxt = mode_r;
            addr_nxt[`DSI_TM_BIT] = 1'b0;
            if (mode_r[`DSI_DLLRST_BIT]) begin
              lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
            end
            mrs_take = 1'b1;
            cnt_nxt = 16'(`DSI_MRD_CYC - 1);
          end else if (sr_req_r) begin
            cmd_nxt = dsi_pkg::CMD_REF;
            cke_nxt = 1'b0;
            st_nxt = CS_SR;
          end else if (pd_req_r) begin
            cke_nxt = 1'b0;
            st_nxt = CS_PD;
          end
        end
        CS_PD: begin
          if (!pd_req_r) begin
            cke_nxt = 1'b1;
            st_nxt = CS_IDLE;
          end
        end
        CS_SR: begin
          if (!sr_req_r) begin
            cke_nxt = 1'b1;
            cnt_nxt = 16'(`DSI_RC_CYC - 1);
            lock_nxt = 8'(`DSI_DLL_LOCK_CYC);
            st_nxt = CS_IDLE;
          end
        end
        default: st_nxt = CS_RESET;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= CS_RESET;
      cnt_r <= 16'h0000;
      lock_r <= 8'h00;
      refs_r <= 4'h0;
      done_r <= 1'b0;
      cke_r <= 1'b0;
      pins_r <= 4'h7;
      ba_r <= 2'b00;
      addr_r <= 13'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lock_r <= lock_nxt;
      refs_r <= refs_nxt;
      done_r <= done_nxt;
      cke_r <= cke_nxt;
      pins_r <= dsi_pkg::dsi_pins(cmd_nxt);
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign ddr.cke = cke_r;
  assign {ddr.cs_n, ddr.ras_n, ddr.cas_n, ddr.we_n} = pins_r;
  assign ddr.ba = ba_r;
  assign ddr.addr = addr_r;
endmodule

// ### sim/dsi_props.sv
// Wire checks on the command link between the controller and SDRAM ends
`include "dsi_params.svh"
module dsi_props #(
  parameter int PWRUP_CYC = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command link
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr
);
  localparam int LOCK = `DSI_DLL_LOCK_CYC;
  int pw_cnt_r;
  int pw_cnt_nxt;
  int lk_cnt_r;
  int lk_cnt_nxt;
  logic sr_r;
  logic sr_nxt;
  logic cke_q_r;
  logic ld;
  logic ref_p;
  logic idle_p;

  assign ld = !cs_n && !ras_n && !cas_n && !we_n;
  assign ref_p = !cs_n && !ras_n && !cas_n && we_n;
  assign idle_p = cs_n || (ras_n && cas_n && we_n);

  // Lock count restarts on any DLL enable or DLL reset write
  always_comb begin
    pw_cnt_nxt = cke ? pw_cnt_r : pw_cnt_r + 1;
    lk_cnt_nxt = (ld && ((!ba[0] && addr[8]) || (ba[0] && !addr[0]))) ? 0 : lk_cnt_r + 1;
    sr_nxt = sr_r;
    if (cke_q_r && !cke && ref_p) begin
      sr_nxt = 1'b1;
    end else if (cke) begin
      sr_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_cnt_r <= 0;
      lk_cnt_r <= 0;
      sr_r <= 1'b0;
      cke_q_r <= 1'b0;
    end else begin
      pw_cnt_r <= pw_cnt_nxt;
      lk_cnt_r <= lk_cnt_nxt;
      sr_r <= sr_nxt;
      cke_q_r <= cke;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  pwrup_hold_a: assert property ($rose(cke) |-> pw_cnt_r >= PWRUP_CYC - 1)
    else $error("clock enable raised before power-up wait");
  fall_cmd_a: assert property ($fell(cke) |-> idle_p || ref_p)
    else $error("clock enable dropped with a bad command");
  emrs_pins_a: assert property ($past(cke) && ld && ba[0] |-> addr[12:1] == 12'h000 && !ba[1])
    else $error("extended mode write with stray address bits");
  mrs_test_a: assert property ($past(cke) && ld && !ba[0] |-> !addr[7])
    else $error("mode write with test bit set");
  mrs_gap_a: assert property ($past(cke) && ld |=> idle_p)
    else $error("command inside mode write interval");
  mrs_cke_a: assert property (ld |-> $past(cke) && cke)
    else $error("mode write without clock enable high");
  sr_exit_a: assert property ($rose(cke) && sr_r |-> idle_p [*3])
    else $error("command too soon after self-refresh exit");
  dll_wait_a: assert property (cke && ref_p |-> lk_cnt_r >= LOCK)
    else $error("refresh before DLL lock time");
endmodule

// ### sim/tb_top.sv
// Bench joining the controller and SDRAM ends over the command link
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 20;
  typedef struct packed {
    logic [12:0] mode;
    logic [2:0] st;
    logic [2:0] bt;
    logic [2:0] col;
    logic legal;
  } dsi_row_type;
  logic hclk, hresetn, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  logic [2:0] start_col, beat, burst_col, bl_code, cl_code;
  logic interleave, test_mode, mode_legal, dll_on, dll_locked, power_down, self_refresh;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int t0 = 0;
  int n_ref = 0;
  dsi_row_type rows [8] = '{'{13'h0032, 3'h1, 3'h3, 3'h0, 1'b1}, '{13'h003A, 3'h3, 3'h1, 3'h2, 1'b1},
    '{13'h0063, 3'h1, 3'h7, 3'h0, 1'b1}, '{13'h006B, 3'h5, 3'h2, 3'h7, 1'b1},
    '{13'h0031, 3'h5, 3'h1, 3'h4, 1'b1}, '{13'h0039, 3'h6, 3'h1, 3'h7, 1'b1},
    '{13'h003B, 3'h3, 3'h3, 3'h0, 1'b1}, '{13'h0072, 3'h2, 3'h3, 3'h1, 1'b0}};

  dsi_if ddr_if();
  dsi_ctrl #(.PWRUP_CYC(PW)) dsi_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ddr(ddr_if.ctrl_mp));
  dsi_dev dsi_dev_inst (.hclk(hclk), .hresetn(hresetn), .ddr(ddr_if.dev_mp), .start_col(start_col),
    .beat(beat), .burst_col(burst_col), .bl_code(bl_code), .interleave(interleave), .cl_code(cl_code),
    .test_mode(test_mode), .mode_legal(mode_legal), .dll_on(dll_on), .dll_locked(dll_locked),
    .power_down(power_down), .self_refresh(self_refresh));
  dsi_props #(.PWRUP_CYC(PW)) dsi_props_inst (.hclk(hclk), .hresetn(hresetn), .cke(ddr_if.cke),
    .cs_n(ddr_if.cs_n), .ras_n(ddr_if.ras_n), .cas_n(ddr_if.cas_n), .we_n(ddr_if.we_n), .ba(ddr_if.ba),
    .addr(ddr_if.addr));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (!hresetn) begin
      n_ref <= 0;
    end else if (ddr_if.cke && {ddr_if.cs_n, ddr_if.ras_n, ddr_if.cas_n, ddr_if.we_n} === 4'h1) begin
      n_ref <= n_ref + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Entered just after a rising edge; zero-wait slave still gets a real handshake
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    for (int i = 0; i < 2000; i++) begin
      bus(a, 1'b0, 32'h0);
      if (q[b] === v) break;
    end
    chk(q[b], v, "poll");
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    chk({ddr_if.cke, hreadyout, power_down, self_refresh, dll_on}, 5'h00, "reset state");
    hresetn <= 1'b1;
    t0 = cyc;
    @(posedge hclk);
    bus(8'h04, 1'b0, 32'h0);
    chk(q, 32'h0000_0032, "mode reset value");
    chk(ddr_if.cke, 1'b0, "cke low at power-up");
    poll(8'h0C, 0, 1'b1);
    chk(cyc - t0 >= PW + 200, 1'b1, "init length");
    chk(n_ref >= 2, 1'b1, "refresh count");
    chk(dll_on, 1'b1, "dll enabled");
    chk({test_mode, interleave, bl_code, cl_code}, {2'h0, 3'h2, 3'h3}, "final mode");
    bus(8'h0C, 1'b0, 32'h0);
    chk(q[5], 1'b1, "read allowed");
    $display("reset and init test done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end

  initial begin
    hresetn = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    start_col = 3'h0;
    beat = 3'h0;
    @(posedge hclk);
    do_reset();
    foreach (rows[i]) begin
      bus(8'h04, 1'b1, {19'h0, rows[i].mode});
      bus(8'h00, 1'b1, 32'h0000_0004);
      poll(8'h00, 2, 1'b0);
      start_col <= rows[i].st;
      beat <= rows[i].bt;
      repeat (3) @(posedge hclk);
      chk({cl_code, interleave, bl_code}, rows[i].mode[6:0], "fields");
      chk(mode_legal, rows[i].legal, "legal");
      chk(burst_col, rows[i].col, "column");
      $display("row %0d done", i);
    end
    bus(8'h00, 1'b1, 32'h0000_0001);
    repeat (6) @(posedge hclk);
    chk({ddr_if.cke, power_down, self_refresh}, 3'b010, "pd entry");
    repeat (10) @(posedge hclk);
    chk(power_down, 1'b1, "pd held");
    bus(8'h0C, 1'b0, 32'h0);
    chk(q[3], 1'b1, "pd status");
    bus(8'h00, 1'b1, 32'h0);
    repeat (4) @(posedge hclk);
    chk(power_down, 1'b0, "pd exit");
    $display("power-down test done");
    bus(8'h08, 1'b1, 32'h0000_0001);
    bus(8'h00, 1'b1, 32'h0000_0008);
    poll(8'h00, 3, 1'b0);
    repeat (3) @(posedge hclk);
    chk(dll_on, 1'b0, "dll disabled");
    // Software view back to enabled, so only the relock timer can block reads
    bus(8'h08, 1'b1, 32'h0);
    bus(8'h00, 1'b1, 32'h0000_0002);
    repeat (6) @(posedge hclk);
    chk({ddr_if.cke, power_down, self_refresh}, 3'b001, "sr entry");
    bus(8'h00, 1'b1, 32'h0);
    repeat (4) @(posedge hclk);
    chk({self_refresh, dll_on, dll_locked}, 3'b010, "sr exit");
    bus(8'h0C, 1'b0, 32'h0);
    chk(q[5], 1'b0, "read blocked");
    repeat (200) @(posedge hclk);
    chk(dll_locked, 1'b1, "relock");
    bus(8'h0C, 1'b0, 32'h0);
    chk(q[5], 1'b1, "read allowed again");
    $display("self-refresh test done");
    bus(8'h10, 1'b1, 32'hFFFF_FFFF);
    bus(8'h10, 1'b0, 32'h0);
    chk(q, 32'h0, "unmapped");
    chk(hresp, 1'b0, "okay response");
    bus(8'h0C, 1'b1, 32'h0);
    bus(8'h0C, 1'b0, 32'h0);
    chk(q[0], 1'b1, "status read-only");
    $display("address map test done");
    // Reset again while parked in self-refresh
    bus(8'h00, 1'b1, 32'h0000_0002);
    repeat (6) @(posedge hclk);
    do_reset();
    bus(8'h08, 1'b0, 32'h0);
    chk(q, 32'h0, "emode reset value");
    results();
  end
endmodule
